// [rtl/dusq_pkg.sv]
package dusq_pkg;
	localparam int DATA_W = 8;
	localparam int CODE_W = 12;
	localparam int NUM_DAC = 16;
	localparam int NUM_CH = 22;
	localparam int NUM_ALARM = 16;
	localparam int FRAME_BITS = 24;
	localparam int NUM_LIMIT = 24;
	localparam int NUM_HYST = 6;

	localparam logic [7:0] ADDR_IF_CFG1 = 8'h01;
	localparam logic [7:0] ADDR_UPDATE = 8'h0f;
	localparam logic [7:0] ADDR_ADC_CFG = 8'h10;
	localparam logic [7:0] ADDR_FALSE_ALARM = 8'h11;
	localparam logic [7:0] ADDR_CHSEL0 = 8'h13;
	localparam logic [7:0] ADDR_CHSEL1 = 8'h14;
	localparam logic [7:0] ADDR_CHSEL2 = 8'h15;
	localparam logic [7:0] ADDR_CLR_TGT0 = 8'h18;
	localparam logic [7:0] ADDR_CLR_TGT1 = 8'h19;
	localparam logic [7:0] ADDR_CLR_SRC0 = 8'h1a;
	localparam logic [7:0] ADDR_CLR_SRC1 = 8'h1b;
	localparam logic [7:0] ADDR_ADC_FIRST = 8'h20;
	localparam logic [7:0] ADDR_ADC_LAST = 8'h4b;
	localparam logic [7:0] ADDR_DAC_FIRST = 8'h50;
	localparam logic [7:0] ADDR_DAC_LAST = 8'h6f;
	localparam logic [7:0] ADDR_ALARM_STAT0 = 8'h70;
	localparam logic [7:0] ADDR_ALARM_STAT1 = 8'h71;
	localparam logic [7:0] ADDR_GEN_STATUS = 8'h72;
	localparam logic [7:0] ADDR_LIMIT_FIRST = 8'h80;
	localparam logic [7:0] ADDR_LIMIT_LAST = 8'h97;
	localparam logic [7:0] ADDR_HYST_FIRST = 8'ha0;
	localparam logic [7:0] ADDR_HYST_LAST = 8'ha5;
	localparam logic [7:0] ADDR_SW_CLR0 = 8'hb0;
	localparam logic [7:0] ADDR_SW_CLR1 = 8'hb1;
	localparam logic [7:0] ADDR_TRIGGER = 8'hc0;

	localparam int DAC_SELECT_A_BIT = 0;
	localparam int UPD_DAC_BIT = 0;
	localparam int UPD_ADC_BIT = 1;
	localparam int ADC_AUTO_BIT = 0;
	localparam int TRIG_BIT = 0;
	localparam int STAT_DAV_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_ALARM_BIT = 2;
	localparam int EXTERNAL_ALARM_INPUT_BIT = 15;
	localparam int HDR_LAST_BIT = 15;
	localparam int RW_BIT = 15;
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_START = 2'b11,
		ST_WAIT = 2'b10
	} dusq_adc_state_t;
endpackage

// [rtl/dusq_core.sv]
`timescale 1ns/100ps
// Operation
// - DAC codes are 12-bit straight binary, zero at bottom, midscale at centre.
// - Host DAC writes land in the buffer register only.
// - Update command copies all DAC buffers into active registers.
// - Each DAC output is driven from its active register.
// - Dac_select_a bit selects buffer or active contents for DAC reads.
// - A cleared DAC is driven with zero code while clear lasts.
// - Entering clear leaves buffer and active registers unchanged.
// - Active dac_select_a of a cleared DAC returns zero; stored value kept.
// - Buffer writes and updates still work while DACs are cleared.
// - Leaving clear drives the DAC at once from its active register.
// - Two software clear registers hold one clear bit per DAC.
// - Alarm events 0 to 14 set their status bits; one enabled as clear source clears every targeted DAC.
// - Clearing the last enabled active alarm restores targeted DAC outputs.
// - ADC config selects direct or auto mode; direct after reset.
// - Direct mode converts each enabled channel once, then returns idle.
// - Auto mode repeats the sequence indefinitely after one trigger.
// - A trigger during auto conversion stops it and returns idle.
// - Bipolar results are stored as 12-bit straight binary codes.
// - Unipolar results are stored as 12-bit codes in their own registers.
// - Trigger is software bit or falling edge on enabled trigger pin.
// - Direct completion sets data-available flag and low pin; start or read clears.
module dusq_core (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic spiCsN,
	input wire logic spiSclk,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoOeN,
	output logic [191:0] dacOutCodes,
	input wire logic [15:0] alarmEvents,
	input wire logic externalAlarmInputN,
	input wire logic gpioTriggerPin,
	input wire logic triggerPinEnable,
	output logic gpioDataReadyPinN,
	output logic adcStart,
	output logic [4:0] adcChannel,
	input wire logic adcDone,
	input wire logic [11:0] adcResult,
	output logic adcBusy
);
	// Serial frame: rw, 7 spare, address, data; sampled on rising sclk
	logic sclkPrev_reg;
	logic [4:0] bitCnt_reg;
	logic [23:0] shiftIn_reg;
	logic [7:0] addr_reg;
	logic isRead_reg;
	logic readPulse_reg;
	logic [7:0] shiftOut_reg;
	wire sclkRise = ~spiCsN & spiSclk & ~sclkPrev_reg;
	wire sclkFall = ~spiCsN & ~spiSclk & sclkPrev_reg;
	wire [23:0] shiftInNext = {shiftIn_reg[22:0], spiSdi};
	wire hdrDone = sclkRise & (bitCnt_reg == 5'(dusq_pkg::HDR_LAST_BIT));
	wire wrStb = sclkRise & (bitCnt_reg == 5'(dusq_pkg::FRAME_BITS - 1)) & ~isRead_reg;
	wire [7:0] wrData = shiftInNext[7:0];
	wire rdStb = readPulse_reg;
	wire [7:0] readData;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sclkPrev_reg <= 1'b0;
			bitCnt_reg <= 5'h00;
			shiftIn_reg <= 24'h000000;
			addr_reg <= 8'h00;
			isRead_reg <= 1'b0;
			readPulse_reg <= 1'b0;
		end else begin
			sclkPrev_reg <= spiSclk;
			readPulse_reg <= hdrDone & shiftInNext[dusq_pkg::RW_BIT];
			if (spiCsN) begin
				bitCnt_reg <= 5'h00;
			end else if (sclkRise) begin
				bitCnt_reg <= bitCnt_reg + 5'h01;
				shiftIn_reg <= shiftInNext;
			end
			if (hdrDone) begin
				addr_reg <= shiftInNext[7:0];
				isRead_reg <= shiftInNext[dusq_pkg::RW_BIT];
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shiftOut_reg <= 8'h00;
		end else if (readPulse_reg) begin
			shiftOut_reg <= readData;
		end else if (sclkFall && bitCnt_reg > 5'(dusq_pkg::HDR_LAST_BIT + 1)) begin
			shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
		end
	end
	assign spiSdo = shiftOut_reg[7];
	assign spiSdoOeN = spiCsN;

	// Register address decode
	wire wrIfCfg = wrStb & (addr_reg == dusq_pkg::ADDR_IF_CFG1);
	wire wrAdcCfg = wrStb & (addr_reg == dusq_pkg::ADDR_ADC_CFG);
	wire wrFalse = wrStb & (addr_reg == dusq_pkg::ADDR_FALSE_ALARM);
	wire inDac = addr_reg >= dusq_pkg::ADDR_DAC_FIRST && addr_reg <= dusq_pkg::ADDR_DAC_LAST;
	wire inAdc = addr_reg >= dusq_pkg::ADDR_ADC_FIRST && addr_reg <= dusq_pkg::ADDR_ADC_LAST;
	wire inLimit = addr_reg >= dusq_pkg::ADDR_LIMIT_FIRST && addr_reg <= dusq_pkg::ADDR_LIMIT_LAST;
	wire inHyst = addr_reg >= dusq_pkg::ADDR_HYST_FIRST && addr_reg <= dusq_pkg::ADDR_HYST_LAST;
	wire [7:0] dacOff = addr_reg - dusq_pkg::ADDR_DAC_FIRST;
	wire [7:0] adcOff = addr_reg - dusq_pkg::ADDR_ADC_FIRST;
	wire [7:0] limOff = addr_reg - dusq_pkg::ADDR_LIMIT_FIRST;
	wire [7:0] hystOff = addr_reg - dusq_pkg::ADDR_HYST_FIRST;
	wire [3:0] dacIdx = dacOff[4:1];
	wire [4:0] adcIdx = adcOff[5:1];
	wire hiByte = ~addr_reg[0];
	wire dacUpdate = wrStb & (addr_reg == dusq_pkg::ADDR_UPDATE) & wrData[dusq_pkg::UPD_DAC_BIT];
	wire adcUpdate = wrStb & (addr_reg == dusq_pkg::ADDR_UPDATE) & wrData[dusq_pkg::UPD_ADC_BIT];
	wire swTrig = wrStb & (addr_reg == dusq_pkg::ADDR_TRIGGER) & wrData[dusq_pkg::TRIG_BIT];

	// Configuration storage
	logic [7:0] ifCfg_reg;
	logic [7:0] adcCfg_reg;
	logic [7:0] falseAlarm_reg;
	logic [23:0] chanSel_reg;
	logic [15:0] clearTarget_reg;
	logic [15:0] clearSource_reg;
	logic [15:0] swClear_reg;
	logic [7:0] limit_reg [0:dusq_pkg::NUM_LIMIT-1];
	logic [7:0] hyst_reg [0:dusq_pkg::NUM_HYST-1];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ifCfg_reg <= dusq_pkg::REG_RESET;
			adcCfg_reg <= dusq_pkg::REG_RESET;
			falseAlarm_reg <= dusq_pkg::REG_RESET;
			chanSel_reg <= 24'h000000;
			clearTarget_reg <= 16'h0000;
			clearSource_reg <= 16'h0000;
			swClear_reg <= 16'h0000;
		end else if (wrStb) begin
			if (wrIfCfg) ifCfg_reg <= wrData;
			if (wrAdcCfg) adcCfg_reg <= wrData;
			if (wrFalse) falseAlarm_reg <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CHSEL0) chanSel_reg[7:0] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CHSEL1) chanSel_reg[15:8] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CHSEL2) chanSel_reg[23:16] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CLR_TGT0) clearTarget_reg[7:0] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CLR_TGT1) clearTarget_reg[15:8] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CLR_SRC0) clearSource_reg[7:0] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_CLR_SRC1) clearSource_reg[15:8] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_SW_CLR0) swClear_reg[7:0] <= wrData;
			if (addr_reg == dusq_pkg::ADDR_SW_CLR1) swClear_reg[15:8] <= wrData;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < dusq_pkg::NUM_LIMIT; i++) limit_reg[i] <= dusq_pkg::REG_RESET;
			for (int i = 0; i < dusq_pkg::NUM_HYST; i++) hyst_reg[i] <= dusq_pkg::REG_RESET;
		end else if (wrStb) begin
			if (inLimit) limit_reg[limOff[4:0]] <= wrData;
			if (inHyst) hyst_reg[hystOff[2:0]] <= wrData;
		end
	end

	// Alarm status: latched until read, external alarm follows its pin
	logic [15:0] alarmStatus_reg;
	wire [15:0] alarmNow = {~externalAlarmInputN, alarmEvents[14:0]};
	wire rdStat0 = rdStb & (addr_reg == dusq_pkg::ADDR_ALARM_STAT0);
	wire rdStat1 = rdStb & (addr_reg == dusq_pkg::ADDR_ALARM_STAT1);
	wire [15:0] statClear = {{8{rdStat1}}, {8{rdStat0}}};
	wire [15:0] alarmStatusNext = (alarmStatus_reg & ~statClear) | alarmNow;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alarmStatus_reg <= 16'h0000;
		end else begin
			alarmStatus_reg <= alarmStatusNext;
			alarmStatus_reg[dusq_pkg::EXTERNAL_ALARM_INPUT_BIT] <= ~externalAlarmInputN;
		end
	end

	// DAC buffer, active and output stages
	logic [11:0] dacBuffer_reg [0:dusq_pkg::NUM_DAC-1];
	logic [11:0] dacActive_reg [0:dusq_pkg::NUM_DAC-1];
	wire clearAlarmActive = |(alarmStatus_reg & clearSource_reg);
	wire [15:0] dacClear = swClear_reg | (clearTarget_reg & {16{clearAlarmActive}});
	wire wrDac = wrStb & inDac;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < dusq_pkg::NUM_DAC; i++) dacBuffer_reg[i] <= 12'h000;
		end else if (wrDac && hiByte) begin
			dacBuffer_reg[dacIdx][11:8] <= wrData[3:0];
		end else if (wrDac) begin
			dacBuffer_reg[dacIdx][7:0] <= wrData;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < dusq_pkg::NUM_DAC; i++) dacActive_reg[i] <= 12'h000;
		end else if (dacUpdate) begin
			for (int i = 0; i < dusq_pkg::NUM_DAC; i++) begin
				dacActive_reg[i] <= dacBuffer_reg[i];
			end
		end
	end

	// Straight binary code to the converter; zero code while cleared
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dacOutCodes <= 192'h0;
		end else begin
			for (int i = 0; i < dusq_pkg::NUM_DAC; i++) begin
				dacOutCodes[i*12 +: 12] <= dacClear[i] ? 12'h000 : dacActive_reg[i];
			end
		end
	end

	// ADC sequencer
	dusq_pkg::dusq_adc_state_t state_reg, state_next;
	logic [4:0] chan_reg, chan_next;
	logic davFlag_reg;
	logic trigPrev_reg;
	logic [11:0] adcWork_reg [0:dusq_pkg::NUM_CH-1];
	logic [11:0] adcView_reg [0:dusq_pkg::NUM_CH-1];
	wire autoMode = adcCfg_reg[dusq_pkg::ADC_AUTO_BIT];
	wire pinTrig = triggerPinEnable & trigPrev_reg & ~gpioTriggerPin;
	wire trigger = swTrig | pinTrig;
	wire [21:0] chanEn = chanSel_reg[21:0];
	wire lastChan = chan_reg == 5'(dusq_pkg::NUM_CH - 1);
	wire seqStart = trigger & (state_reg == dusq_pkg::ST_IDLE) & (|chanEn);
	wire stopAuto = trigger & (state_reg != dusq_pkg::ST_IDLE);
	wire scanEnd = (state_reg == dusq_pkg::ST_SCAN) & ~chanEn[chan_reg] & lastChan;
	wire convEnd = (state_reg == dusq_pkg::ST_WAIT) & adcDone & lastChan;
	wire seqEnd = scanEnd | convEnd;
	wire directDone = seqEnd & ~autoMode;
	wire storeResult = (state_reg == dusq_pkg::ST_WAIT) & adcDone;
	wire rdAdcData = rdStb & inAdc;

	always_comb begin
		state_next = state_reg;
		chan_next = chan_reg;
		unique case (state_reg)
			dusq_pkg::ST_IDLE: begin
				if (seqStart) begin
					state_next = dusq_pkg::ST_SCAN;
					chan_next = 5'h00;
				end
			end
			dusq_pkg::ST_SCAN: begin
				if (chanEn[chan_reg]) begin
					state_next = dusq_pkg::ST_START;
				end else if (lastChan) begin
					state_next = autoMode ? dusq_pkg::ST_SCAN : dusq_pkg::ST_IDLE;
					chan_next = 5'h00;
				end else begin
					chan_next = chan_reg + 5'h01;
				end
			end
			dusq_pkg::ST_START: state_next = dusq_pkg::ST_WAIT;
			dusq_pkg::ST_WAIT: begin
				if (adcDone && lastChan) begin
					state_next = autoMode ? dusq_pkg::ST_SCAN : dusq_pkg::ST_IDLE;
					chan_next = 5'h00;
				end else if (adcDone) begin
					state_next = dusq_pkg::ST_SCAN;
					chan_next = chan_reg + 5'h01;
				end
			end
		endcase
		if (stopAuto && autoMode) begin
			state_next = dusq_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= dusq_pkg::ST_IDLE;
			chan_reg <= 5'h00;
			trigPrev_reg <= 1'b1;
			davFlag_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			chan_reg <= chan_next;
			trigPrev_reg <= gpioTriggerPin;
			davFlag_reg <= directDone | (davFlag_reg & ~seqStart & ~rdAdcData);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < dusq_pkg::NUM_CH; i++) adcWork_reg[i] <= 12'h000;
		end else if (storeResult) begin
			adcWork_reg[chan_reg] <= adcResult;
		end
	end

	// Visible copy: refreshed at direct completion, or by update command in either mode
	wire [11:0] workLast = storeResult ? adcResult : adcWork_reg[chan_reg];
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < dusq_pkg::NUM_CH; i++) adcView_reg[i] <= 12'h000;
		end else if (directDone || adcUpdate) begin
			for (int i = 0; i < dusq_pkg::NUM_CH; i++) begin
				adcView_reg[i] <= (i == int'(chan_reg)) ? workLast : adcWork_reg[i];
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			adcStart <= 1'b0;
			adcChannel <= 5'h00;
			gpioDataReadyPinN <= 1'b1;
		end else begin
			adcStart <= (state_next == dusq_pkg::ST_START);
			adcChannel <= chan_next;
			gpioDataReadyPinN <= ~(directDone | (davFlag_reg & ~seqStart & ~rdAdcData));
		end
	end
	assign adcBusy = state_reg != dusq_pkg::ST_IDLE;

	// Read data selection
	wire readActive = ifCfg_reg[dusq_pkg::DAC_SELECT_A_BIT];
	wire [11:0] dacShown = readActive ? (dacClear[dacIdx] ? 12'h000 : dacActive_reg[dacIdx])
		: dacBuffer_reg[dacIdx];
	wire [11:0] adcShown = adcView_reg[adcIdx];
	wire [7:0] dacByte = hiByte ? {4'h0, dacShown[11:8]} : dacShown[7:0];
	wire [7:0] adcByte = hiByte ? {4'h0, adcShown[11:8]} : adcShown[7:0];
	wire [7:0] genStatus = {5'h00, |alarmStatus_reg, adcBusy, davFlag_reg};
	assign readData =
		inDac ? dacByte :
		inAdc ? adcByte :
		inLimit ? limit_reg[limOff[4:0]] :
		inHyst ? hyst_reg[hystOff[2:0]] :
		(addr_reg == dusq_pkg::ADDR_IF_CFG1) ? ifCfg_reg :
		(addr_reg == dusq_pkg::ADDR_ADC_CFG) ? adcCfg_reg :
		(addr_reg == dusq_pkg::ADDR_FALSE_ALARM) ? falseAlarm_reg :
		(addr_reg == dusq_pkg::ADDR_CHSEL0) ? chanSel_reg[7:0] :
		(addr_reg == dusq_pkg::ADDR_CHSEL1) ? chanSel_reg[15:8] :
		(addr_reg == dusq_pkg::ADDR_CHSEL2) ? chanSel_reg[23:16] :
		(addr_reg == dusq_pkg::ADDR_CLR_TGT0) ? clearTarget_reg[7:0] :
		(addr_reg == dusq_pkg::ADDR_CLR_TGT1) ? clearTarget_reg[15:8] :
		(addr_reg == dusq_pkg::ADDR_CLR_SRC0) ? clearSource_reg[7:0] :
		(addr_reg == dusq_pkg::ADDR_CLR_SRC1) ? clearSource_reg[15:8] :
		(addr_reg == dusq_pkg::ADDR_ALARM_STAT0) ? alarmStatus_reg[7:0] :
		(addr_reg == dusq_pkg::ADDR_ALARM_STAT1) ? alarmStatus_reg[15:8] :
		(addr_reg == dusq_pkg::ADDR_GEN_STATUS) ? genStatus :
		(addr_reg == dusq_pkg::ADDR_SW_CLR0) ? swClear_reg[7:0] :
		(addr_reg == dusq_pkg::ADDR_SW_CLR1) ? swClear_reg[15:8] :
		8'h00;

	update_copy_a: assert property (@(posedge core_clk) disable iff (!resetn)
		dacUpdate |=> dacActive_reg[0] == $past(dacBuffer_reg[0]))
		else $error("update did not copy buffer to active");
	buffer_only_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(wrDac && !dacUpdate) |=> $stable(dacActive_reg[0]))
		else $error("buffer write changed active register");
	clear_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
		dacClear[0] |=> dacOutCodes[11:0] == 12'h000)
		else $error("cleared DAC not at zero code");
	normal_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(!dacClear[0] && !dacUpdate) |=> dacOutCodes[11:0] == dacActive_reg[0])
		else $error("DAC output not following active register");
	direct_end_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(convEnd && !autoMode && !trigger) |=> state_reg == dusq_pkg::ST_IDLE && davFlag_reg)
		else $error("direct sequence did not end idle with flag");
	auto_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(stopAuto && autoMode) |=> state_reg == dusq_pkg::ST_IDLE ##1 !adcBusy || seqStart)
		else $error("second trigger did not stop auto mode");
	auto_repeat_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(convEnd && autoMode && !trigger) |=> state_reg == dusq_pkg::ST_SCAN && chan_reg == 5'h00)
		else $error("auto sequence did not restart");
	dav_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(davFlag_reg) |-> !gpioDataReadyPinN ##1 (davFlag_reg == !gpioDataReadyPinN))
		else $error("data ready pin disagrees with flag");
	alarm_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
		alarmEvents[3] |=> alarmStatus_reg[3])
		else $error("alarm event lost");
	alarm_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(|(alarmStatus_reg & clearSource_reg)) |-> ((clearTarget_reg & ~dacClear) == 16'h0000))
		else $error("enabled alarm did not clear target DAC");
endmodule

// [bench/dusq_conv_model.sv]
`timescale 1ns/100ps
module dusq_conv_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic adcStart,
	input wire logic [4:0] adcChannel,
	input wire logic slow,
	output logic adcDone,
	output logic [11:0] adcResult
);
	int cnt;
	logic [4:0] chHeld;
	// Result outside its done cycle flips every cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			adcDone <= 1'b0;
			adcResult <= 12'h000;
			chHeld <= 5'h00;
		end else begin
			adcDone <= 1'b0;
			adcResult <= ~adcResult;
			if (adcStart) begin
				chHeld <= adcChannel;
				cnt <= slow ? 9 : 2;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					adcDone <= 1'b1;
					adcResult <= {7'h5a, chHeld};
				end
			end
		end
	end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic spiCsN = 1'b1;
	logic spiSclk = 1'b0;
	logic spiSdi = 1'b0;
	logic [15:0] alarmEvents = 16'h0000;
	logic externalAlarmInputN = 1'b1;
	logic gpioTriggerPin = 1'b1;
	logic triggerPinEnable = 1'b0;
	logic slow = 1'b0;
	logic spiSdo, spiSdoOeN, gpioDataReadyPinN, adcStart, adcDone, adcBusy;
	logic [191:0] dacOutCodes;
	logic [4:0] adcChannel;
	logic [11:0] adcResult;
	int n_errors = 0;
	int compares = 0;
	int starts = 0;
	int bufM[16];
	int actM[16];
	logic sel = 1'b0;
	logic [15:0] clrM = 16'h0000;
	logic [15:0] tgt;
	logic [4:0] chq[$];
	logic [7:0] q;
	int chList[3] = '{2, 17, 21};
	always #25 core_clk = ~core_clk;
	dusq_core u_dusq_core (.core_clk, .resetn, .spiCsN, .spiSclk, .spiSdi, .spiSdo, .spiSdoOeN,
		.dacOutCodes, .alarmEvents, .externalAlarmInputN, .gpioTriggerPin, .triggerPinEnable,
		.gpioDataReadyPinN, .adcStart, .adcChannel, .adcDone, .adcResult, .adcBusy);
	dusq_conv_model u_dusq_conv_model (.core_clk, .resetn, .adcStart, .adcChannel, .slow,
		.adcDone, .adcResult);
	always @(posedge core_clk) begin
		if (adcStart === 1'b1) begin
			starts++;
			chq.push_back(adcChannel);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {r, 7'h00, a, d};
		spiCsN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spiSdi = f[i];
			cyc(4);
			if (i < 8) q[i] = spiSdo;
			spiSclk = 1'b1;
			cyc(4);
			spiSclk = 1'b0;
		end
		cyc(3);
		spiCsN = 1'b1;
		cyc(3);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		xfer(1'b1, a, 8'h00);
	endtask
	task automatic give_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] e);
		compares++;
		if (q !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, q);
		end
	endtask
	task automatic chk_sig(input string nm, input logic [191:0] e, input logic [191:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [191:0] expOut();
		logic [191:0] v;
		for (int i = 0; i < 16; i++) v[i*12 +: 12] = clrM[i] ? 12'h000 : 12'(actM[i]);
		return v;
	endfunction
	task automatic wdac(input int i);
		logic [11:0] c;
		c = 12'($urandom);
		wr(8'(8'h50 + 2 * i), {4'h0, c[11:8]});
		wr(8'(8'h51 + 2 * i), c[7:0]);
		bufM[i] = int'(c);
	endtask
	task automatic rdac(input int i);
		int e;
		e = !sel ? bufM[i] : (clrM[i] ? 0 : actM[i]);
		rd(8'(8'h50 + 2 * i));
		chk_reg("dac hi", 8'(e >> 8));
		rd(8'(8'h51 + 2 * i));
		chk_reg("dac lo", 8'(e));
	endtask
	task automatic upd;
		wr(8'h0f, 8'h01);
		actM = bufM;
	endtask
	initial begin
		repeat (50000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end
	initial begin
		void'($urandom(93356));
		for (int i = 0; i < 16; i++) actM[i] = 0;
		cyc(3);
		resetn = 1'b1;
		cyc(2);
		chk_sig("pins", 192'h2, {gpioDataReadyPinN, adcBusy});
		rd(8'h10);
		chk_reg("adc cfg", 8'h00);
		wr(8'hff, 8'h5a);
		rd(8'hff);
		chk_reg("unmapped", 8'h00);
		for (int i = 0; i < 16; i++) wdac(i);
		chk_sig("dac out", expOut(), dacOutCodes);
		for (int i = 0; i < 16; i++) rdac(i);
		sel = 1'b1;
		wr(8'h01, 8'h01);
		for (int i = 0; i < 4; i++) rdac(i);
		upd();
		chk_sig("dac out", expOut(), dacOutCodes);
		wdac(5);
		chk_sig("dac out", expOut(), dacOutCodes);
		for (int i = 0; i < 16; i++) rdac(i);
		clrM = 16'($urandom);
		wr(8'hb0, clrM[7:0]);
		wr(8'hb1, clrM[15:8]);
		chk_sig("dac out", expOut(), dacOutCodes);
		for (int i = 0; i < 16; i++) rdac(i);
		for (int i = 0; i < 4; i++) wdac(i);
		upd();
		chk_sig("dac out", expOut(), dacOutCodes);
		for (int i = 0; i < 4; i++) rdac(i);
		clrM = 16'h0000;
		wr(8'hb0, 8'h00);
		wr(8'hb1, 8'h00);
		chk_sig("dac out", expOut(), dacOutCodes);
		tgt = 16'($urandom);
		wr(8'h18, tgt[7:0]);
		wr(8'h19, tgt[15:8]);
		wr(8'h1a, 8'h08);
		wr(8'h1b, 8'h80);
		alarmEvents[3] = 1'b1;
		cyc(1);
		alarmEvents = 16'h0000;
		cyc(3);
		clrM = tgt;
		chk_sig("dac out", expOut(), dacOutCodes);
		rd(8'h70);
		chk_reg("alarm stat", 8'h08);
		clrM = 16'h0000;
		chk_sig("dac out", expOut(), dacOutCodes);
		externalAlarmInputN = 1'b0;
		cyc(3);
		clrM = tgt;
		chk_sig("dac out", expOut(), dacOutCodes);
		externalAlarmInputN = 1'b1;
		cyc(3);
		clrM = 16'h0000;
		chk_sig("dac out", expOut(), dacOutCodes);
		wr(8'h13, 8'h04);
		wr(8'h15, 8'h22);
		cyc(40);
		starts = 0;
		chq.delete();
		wr(8'hc0, 8'h01);
		for (int k = 0; k < 400 && adcBusy; k++) cyc(1);
		chk_sig("dav pin", 192'h0, {adcBusy, gpioDataReadyPinN});
		cyc(50);
		chk_sig("starts", 192'd3, 192'(starts));
		chk_sig("order", {5'd2, 5'd17, 5'd21}, {chq[0], chq[1], chq[2]});
		foreach (chList[n]) begin
			rd(8'(8'h20 + 2 * chList[n]));
			chk_reg("adc hi", 8'h0b);
			rd(8'(8'h21 + 2 * chList[n]));
			chk_reg("adc lo", {3'b010, 5'(chList[n])});
		end
		chk_sig("dav pin", 192'h1, gpioDataReadyPinN);
		wr(8'h10, 8'h01);
		cyc(40);
		slow = 1'b1;
		starts = 0;
		triggerPinEnable = 1'b1;
		gpioTriggerPin = 1'b0;
		cyc(300);
		gpioTriggerPin = 1'b1;
		chk_sig("auto runs", 192'h1, 192'(starts > 6));
		wr(8'hc0, 8'h01);
		chk_sig("busy", 192'h0, adcBusy);
		starts = 0;
		cyc(50);
		chk_sig("starts", 192'd0, 192'(starts));
		wr(8'h0f, 8'h02);
		rd(8'h25);
		chk_reg("auto data", 8'h42);
		give_verdict();
	end
endmodule
